// >>> include/cbsd_pkg.sv
package cbsd_pkg;
  localparam int STEP_W  = 8;
  localparam int PAGE_W  = 4;
  localparam int PC_W    = 13;
  localparam int DADDR_W = 12;
  localparam int WORD_W  = 12;
  localparam int CNT_W   = 4;

  localparam logic [PC_W-1:0] PC_RESET     = 13'h0100;
  localparam logic [7:0]      SP_RESET     = 8'h00;
  localparam logic [3:0]      STACK_PAGE   = 4'h0;
  localparam logic [3:0]      ZERO_PAGE    = 4'h0;
  localparam logic [7:0]      INC8         = 8'h01;
  localparam logic [7:0]      SLOT2        = 8'h02;
  localparam logic [7:0]      FRAME        = 8'h03;
  localparam logic [3:0]      INC4         = 4'h1;
  localparam logic [4:0]      DEC_MAX      = 5'h09;
  localparam logic [4:0]      DEC_ADJ      = 5'h06;

  // Avalon byte offsets, one word each
  localparam logic [5:0] OFS_CTRL  = 6'h00;
  localparam logic [5:0] OFS_PC    = 6'h04;
  localparam logic [5:0] OFS_FLAG  = 6'h08;
  localparam logic [5:0] OFS_AB    = 6'h0c;
  localparam logic [5:0] OFS_X     = 6'h10;
  localparam logic [5:0] OFS_Y     = 6'h14;
  localparam logic [5:0] OFS_SP    = 6'h18;
  localparam logic [5:0] OFS_PADDR = 6'h1c;
  localparam logic [5:0] OFS_PDATA = 6'h20;
  localparam logic [5:0] OFS_DADDR = 6'h24;
  localparam logic [5:0] OFS_DDATA = 6'h28;

  // Micro-step numbers within one instruction, then the per-instruction cycle costs
  localparam logic [CNT_W-1:0] CNT_FETCH = 4'h0;
  localparam logic [CNT_W-1:0] CNT_M1    = 4'h1;
  localparam logic [CNT_W-1:0] CNT_M2    = 4'h2;
  localparam logic [CNT_W-1:0] CNT_M3    = 4'h3;
  localparam logic [CNT_W-1:0] CNT_M4    = 4'h4;
  localparam logic [CNT_W-1:0] CNT_M5    = 4'h5;
  localparam logic [CNT_W-1:0] CNT_M6    = 4'h6;
  localparam logic [CNT_W-1:0] CYC_SHORT = 4'h5;
  localparam logic [CNT_W-1:0] CYC_MID   = 4'h7;
  localparam logic [CNT_W-1:0] CYC_LONG  = 4'hc;

  localparam logic [1:0] RC_A  = 2'h0;
  localparam logic [1:0] RC_B  = 2'h1;
  localparam logic [1:0] RC_MX = 2'h2;
  localparam logic [1:0] RC_MY = 2'h3;

  typedef enum logic [4:0] {
    OP_JP, OP_JPC, OP_JPNC, OP_JPZ, OP_JPNZ, OP_JUMP_REGISTER_INDIRECT_OP, OP_CALL, OP_ZERO_PAGE_CALL_OP,
    OP_RET, OP_RETURN_SKIP_OP, OP_RETURN_WITH_DATA_OP, OP_PAGE_SET_OP, OP_IDLE_FIVE_CYCLES_OP, OP_IDLE_SEVEN_CYCLES_OP, OP_HALT,
    OP_INCX, OP_INCY, OP_LDX, OP_LDY, OP_ADD, OP_OTHER
  } cbsd_op_t;

  function automatic cbsd_op_t cbsd_decode(input logic [WORD_W-1:0] w);
    casez (w)
      12'h0??: return OP_JP;
      12'h1??: return OP_RETURN_WITH_DATA_OP;
      12'h2??: return OP_JPC;
      12'h3??: return OP_JPNC;
      12'h4??: return OP_CALL;
      12'h5??: return OP_ZERO_PAGE_CALL_OP;
      12'h6??: return OP_JPZ;
      12'h7??: return OP_JPNZ;
      12'h8??: return OP_LDY;
      12'hb??: return OP_LDX;
      12'b1100_00??_????: return OP_ADD;
      12'b1110_010?_????: return OP_PAGE_SET_OP;
      12'hee0: return OP_INCX;
      12'hef0: return OP_INCY;
      12'hfe8: return OP_JUMP_REGISTER_INDIRECT_OP;
      12'hfdf: return OP_RET;
      12'hfde: return OP_RETURN_SKIP_OP;
      12'hffb: return OP_IDLE_FIVE_CYCLES_OP;
      12'hfff: return OP_IDLE_SEVEN_CYCLES_OP;
      12'hff8: return OP_HALT;
      default: return OP_OTHER;
    endcase
  endfunction : cbsd_decode

  function automatic logic [CNT_W-1:0] cbsd_cost(input cbsd_op_t k);
    case (k)
      OP_CALL, OP_ZERO_PAGE_CALL_OP, OP_RET, OP_IDLE_SEVEN_CYCLES_OP, OP_ADD: return CYC_MID;
      OP_RETURN_SKIP_OP, OP_RETURN_WITH_DATA_OP: return CYC_LONG;
      default: return CYC_SHORT;
    endcase
  endfunction : cbsd_cost
endpackage : cbsd_pkg

// >>> hdl/cbsd_prog_ram.sv
`timescale 1ns/100ps
module cbsd_prog_ram
  import cbsd_pkg::*;
#(
  parameter int ADDR_W = PC_W,
  parameter int DATA_W = WORD_W
)
(
  input  wire logic              sys_clk,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule : cbsd_prog_ram

// >>> hdl/cbsd_data_ram.sv
`timescale 1ns/100ps
module cbsd_data_ram
  import cbsd_pkg::*;
#(
  parameter int ADDR_W = DADDR_W,
  parameter int DATA_W = 4
)
(
  input  wire logic              sys_clk,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Read-first: a write cycle still returns the old nibble
  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : cbsd_data_ram

// >>> hdl/cbsd_core.sv
`timescale 1ns/100ps
// Contract
// - Keep interrupt, decimal, zero and carry flags; conditional jumps test zero/carry.
// - With decimal flag set, add results are decimal adjusted.
// - Page-set loads bit 4 into new bank, bits 3-0 into new page; 5 cycles.
// - Jump and call targets are an 8-bit step loaded into the step field.
// - Jump loads bank, page from new pointers and step from immediate; 5 cycles.
// - Carry jumps load only when carry is 1 or 0 as coded, else sequential.
// - Zero jumps load only when zero is 1 or 0 as coded, else sequential.
// - Indirect jump loads bank, page from pointers, step from B:A; 5 cycles.
// - Call pushes page, step high, step low plus one; SP-3; new page; 7 cycles.
// - Zero-page call pushes same frame, forces page 0, step from immediate; 7 cycles.
// - Return pops step low, step high, page from SP..SP+2; SP+3; 7 cycles.
// - Return-skip pops as return then adds one to the step; 12 cycles.
// - Return-data pops, writes immediate nibbles at X and X+1, X+2; 12 cycles.
// - Two idle opcodes change nothing, lasting 5 and 7 cycles.
// - Load X writes immediate high nibble to X high, low to X low; 5 cycles.
// - Load Y writes immediate high nibble to Y high, low to Y low; 5 cycles.
// - Register code 00 A, 01 B, 10 memory at X, 11 memory at Y.
module cbsd_core
  import cbsd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             core_halted
);
  logic                 run;
  logic [CNT_W-1:0]     cnt;
  logic [CNT_W-1:0]     last;
  logic                 commit;
  logic                 idle;
  logic                 pc_bank;
  logic [PAGE_W-1:0]    pc_page;
  logic [STEP_W-1:0]    pc_step;
  logic [PC_W-1:0]      next_pc;
  logic                 new_bank_pointer;
  logic [PAGE_W-1:0]    new_page_pointer;
  logic                 flag_i;
  logic                 flag_d;
  logic                 flag_z;
  logic                 flag_c;
  logic [3:0]           reg_a;
  logic [3:0]           reg_b;
  logic [3:0]           x_page;
  logic [7:0]           x_low;
  logic [3:0]           y_page;
  logic [7:0]           y_low;
  logic [7:0]           sp;
  logic [3:0]           pop_lo;
  logic [3:0]           pop_hi;
  logic [3:0]           pop_pg;
  logic [PC_W-1:0]      paddr;
  logic [DADDR_W-1:0]   daddr;
  logic [WORD_W-1:0]    prog_rdata;
  logic [3:0]           dm_rdata;
  logic [3:0]           dm_wdata;
  logic [DADDR_W-1:0]   dm_addr;
  logic                 dm_we;
  cbsd_op_t             op;
  logic [7:0]           imm;
  logic [1:0]           rcode;
  logic [4:0]           add_sum;
  logic                 add_now;
  logic                 bus_wr;
  logic [31:0]          bus_rdata;
  logic [31:0]          merged;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  function automatic logic [3:0] reg_select(input logic [1:0] code,
                                            input logic [3:0] a, b, m);
    case (code)
      RC_A:    return a;
      RC_B:    return b;
      default: return m;
    endcase
  endfunction : reg_select

  function automatic logic [4:0] add_nibble(input logic [3:0] a, b, input logic dec);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (dec && (s > DEC_MAX))
    begin
      s = 5'(s + DEC_ADJ);
    end
    return s;
  endfunction : add_nibble

  function automatic logic [DADDR_W-1:0] stack_addr(input logic [7:0] s);
    return {STACK_PAGE, s};
  endfunction : stack_addr

  cbsd_prog_ram u_prog_ram (
    .sys_clk (sys_clk),
    .wr_en   (idle && bus_wr && avs_address == OFS_PDATA),
    .wr_addr (paddr),
    .wr_data (merged[WORD_W-1:0]),
    .rd_addr ({pc_bank, pc_page, pc_step}),
    .rd_data (prog_rdata)
  );

  cbsd_data_ram u_data_ram (
    .sys_clk (sys_clk),
    .we      (dm_we),
    .addr    (dm_addr),
    .wdata   (dm_wdata),
    .rdata   (dm_rdata)
  );

  assign op      = cbsd_decode(prog_rdata);
  assign imm     = prog_rdata[7:0];
  assign rcode   = prog_rdata[5:4];
  assign last    = cbsd_cost(op) - INC4;
  assign commit  = (cnt != CNT_FETCH) && (cnt == last);
  assign idle    = (cnt == CNT_FETCH) && !run;
  assign bus_wr  = avs_write && !avs_waitrequest;
  assign merged  = lane_merge(bus_rdata, avs_writedata, avs_byteenable);
  assign add_now = (op == OP_ADD) && (cnt == CNT_M3);
  // Operand comes from A, B or the nibble read one step earlier
  assign add_sum = add_nibble(reg_select(rcode, reg_a, reg_b, dm_rdata),
                              prog_rdata[3:0], flag_d);

  // Bus slave: one wait state on every access
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      avs_readdata <= 32'h0;
    end
    else if (avs_read && avs_waitrequest)
    begin
      avs_readdata <= bus_rdata;
    end
  end

  always_comb
  begin
    case (avs_address)
      OFS_CTRL:  bus_rdata = {30'h0, core_halted, run};
      OFS_PC:    bus_rdata = {19'h0, pc_bank, pc_page, pc_step};
      OFS_FLAG:  bus_rdata = {28'h0, flag_i, flag_d, flag_z, flag_c};
      OFS_AB:    bus_rdata = {24'h0, reg_b, reg_a};
      OFS_X:     bus_rdata = {20'h0, x_page, x_low};
      OFS_Y:     bus_rdata = {20'h0, y_page, y_low};
      OFS_SP:    bus_rdata = {24'h0, sp};
      OFS_PADDR: bus_rdata = {19'h0, paddr};
      OFS_PDATA: bus_rdata = {20'h0, prog_rdata};
      OFS_DADDR: bus_rdata = {20'h0, daddr};
      OFS_DDATA: bus_rdata = {28'h0, dm_rdata};
      default:   bus_rdata = 32'h0;
    endcase
  end

  // Run control; in the same cycle a software start wins over a halt for run, while the halt still wins for core_halted
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      run <= 1'b0;
    end
    else
    begin
      if (commit && op == OP_HALT)
      begin
        run <= 1'b0;
      end
      if (bus_wr && avs_address == OFS_CTRL)
      begin
        run <= merged[0];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      core_halted <= 1'b0;
    end
    else
    begin
      if (bus_wr && avs_address == OFS_CTRL && merged[0])
      begin
        core_halted <= 1'b0;
      end
      if (commit && op == OP_HALT)
      begin
        core_halted <= 1'b1;
      end
    end
  end

  // Step counter paces every opcode to its documented cost
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cnt <= CNT_FETCH;
    end
    else if (cnt == CNT_FETCH)
    begin
      cnt <= run ? CNT_M1 : CNT_FETCH;
    end
    else if (commit)
    begin
      cnt <= CNT_FETCH;
    end
    else
    begin
      cnt <= cnt + INC4;
    end
  end

  always_comb
  begin
    next_pc = {pc_bank, pc_page, 8'(pc_step + INC8)};
    case (op)
      OP_JP:   next_pc = {new_bank_pointer, new_page_pointer, imm};
      OP_JPC:  if (flag_c) next_pc = {new_bank_pointer, new_page_pointer, imm};
      OP_JPNC: if (!flag_c) next_pc = {new_bank_pointer, new_page_pointer, imm};
      OP_JPZ:  if (flag_z) next_pc = {new_bank_pointer, new_page_pointer, imm};
      OP_JPNZ: if (!flag_z) next_pc = {new_bank_pointer, new_page_pointer, imm};
      OP_JUMP_REGISTER_INDIRECT_OP: next_pc = {new_bank_pointer, new_page_pointer, reg_b, reg_a};
      OP_CALL: next_pc = {pc_bank, new_page_pointer, imm};
      OP_ZERO_PAGE_CALL_OP: next_pc = {pc_bank, ZERO_PAGE, imm};
      OP_RET:  next_pc = {pc_bank, pop_pg, pop_hi, pop_lo};
      OP_RETURN_WITH_DATA_OP: next_pc = {pc_bank, pop_pg, pop_hi, pop_lo};
      OP_RETURN_SKIP_OP: next_pc = {pc_bank, pop_pg, 8'({pop_hi, pop_lo} + INC8)};
      default: ;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      {pc_bank, pc_page, pc_step} <= PC_RESET;
    end
    else if (idle && bus_wr && avs_address == OFS_PC)
    begin
      {pc_bank, pc_page, pc_step} <= merged[PC_W-1:0];
    end
    else if (commit)
    begin
      {pc_bank, pc_page, pc_step} <= next_pc;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      {new_bank_pointer, new_page_pointer} <= PC_RESET[PC_W-1:STEP_W];
    end
    else if (commit && op == OP_PAGE_SET_OP)
    begin
      {new_bank_pointer, new_page_pointer} <= prog_rdata[4:0];
    end
  end

  // Data memory port: the bus owns it only while the core is stopped
  always_comb
  begin
    dm_addr  = daddr;
    dm_we    = 1'b0;
    dm_wdata = merged[3:0];
    if (idle)
    begin
      dm_we = bus_wr && avs_address == OFS_DDATA;
    end
    else
    begin
      case (op)
        OP_CALL, OP_ZERO_PAGE_CALL_OP:
        begin
          dm_we = (cnt == CNT_M1) || (cnt == CNT_M2) || (cnt == CNT_M3);
          case (cnt)
            CNT_M1:
            begin
              dm_addr  = stack_addr(sp - INC8);
              dm_wdata = pc_page;
            end
            CNT_M2:
            begin
              dm_addr  = stack_addr(sp - SLOT2);
              dm_wdata = pc_step[7:4];
            end
            default:
            begin
              dm_addr  = stack_addr(sp - FRAME);
              dm_wdata = pc_step[3:0] + INC4;
            end
          endcase
        end
        OP_RET, OP_RETURN_SKIP_OP, OP_RETURN_WITH_DATA_OP:
        begin
          case (cnt)
            CNT_M1:  dm_addr = stack_addr(sp);
            CNT_M2:  dm_addr = stack_addr(sp + INC8);
            CNT_M3:  dm_addr = stack_addr(sp + SLOT2);
            CNT_M5:  dm_addr = {x_page, x_low};
            default: dm_addr = {x_page, 8'(x_low + INC8)};
          endcase
          dm_we    = (op == OP_RETURN_WITH_DATA_OP) && (cnt == CNT_M5 || cnt == CNT_M6);
          dm_wdata = (cnt == CNT_M5) ? imm[3:0] : imm[7:4];
        end
        OP_ADD:
        begin
          dm_addr  = (rcode == RC_MX) ? {x_page, x_low} : {y_page, y_low};
          dm_we    = add_now && (rcode == RC_MX || rcode == RC_MY);
          dm_wdata = add_sum[3:0];
        end
        default: ;
      endcase
    end
  end

  // Return frame capture, one nibble per step after each read
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pop_lo <= 4'h0;
      pop_hi <= 4'h0;
      pop_pg <= 4'h0;
    end
    else
    begin
      if (cnt == CNT_M2)
      begin
        pop_lo <= dm_rdata;
      end
      if (cnt == CNT_M3)
      begin
        pop_hi <= dm_rdata;
      end
      if (cnt == CNT_M4)
      begin
        pop_pg <= dm_rdata;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sp <= SP_RESET;
    end
    else if (idle && bus_wr && avs_address == OFS_SP)
    begin
      sp <= merged[7:0];
    end
    else if (commit && (op == OP_CALL || op == OP_ZERO_PAGE_CALL_OP))
    begin
      sp <= sp - FRAME;
    end
    else if (commit && (op == OP_RET || op == OP_RETURN_SKIP_OP || op == OP_RETURN_WITH_DATA_OP))
    begin
      sp <= sp + FRAME;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      {flag_i, flag_d, flag_z, flag_c} <= 4'h0;
    end
    else if (idle && bus_wr && avs_address == OFS_FLAG)
    begin
      {flag_i, flag_d, flag_z, flag_c} <= merged[3:0];
    end
    else if (add_now)
    begin
      flag_c <= add_sum[4];
      flag_z <= (add_sum[3:0] == 4'h0);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      reg_a <= 4'h0;
      reg_b <= 4'h0;
    end
    else if (idle && bus_wr && avs_address == OFS_AB)
    begin
      {reg_b, reg_a} <= merged[7:0];
    end
    else if (add_now && rcode == RC_A)
    begin
      reg_a <= add_sum[3:0];
    end
    else if (add_now && rcode == RC_B)
    begin
      reg_b <= add_sum[3:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      {x_page, x_low} <= 12'h000;
    end
    else if (idle && bus_wr && avs_address == OFS_X)
    begin
      {x_page, x_low} <= merged[11:0];
    end
    else if (commit && op == OP_LDX)
    begin
      x_low <= imm;
    end
    else if (commit && op == OP_INCX)
    begin
      x_low <= x_low + INC8;
    end
    else if (commit && op == OP_RETURN_WITH_DATA_OP)
    begin
      x_low <= x_low + SLOT2;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      {y_page, y_low} <= 12'h000;
    end
    else if (idle && bus_wr && avs_address == OFS_Y)
    begin
      {y_page, y_low} <= merged[11:0];
    end
    else if (commit && op == OP_LDY)
    begin
      y_low <= imm;
    end
    else if (commit && op == OP_INCY)
    begin
      y_low <= y_low + INC8;
    end
  end

  // Loader pointers step after each data write for burst filling
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      paddr <= '0;
      daddr <= '0;
    end
    else
    begin
      if (bus_wr && avs_address == OFS_PADDR)
      begin
        paddr <= merged[PC_W-1:0];
      end
      else if (idle && bus_wr && avs_address == OFS_PDATA)
      begin
        paddr <= paddr + PC_W'(1);
      end
      if (bus_wr && avs_address == OFS_DADDR)
      begin
        daddr <= merged[DADDR_W-1:0];
      end
      else if (idle && bus_wr && avs_address == OFS_DDATA)
      begin
        daddr <= daddr + DADDR_W'(1);
      end
    end
  end
endmodule : cbsd_core

// >>> dv/cbsd_core_chk.sv
`timescale 1ns/100ps
module cbsd_core_chk
  import cbsd_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        core_halted
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");
  chk_reset_outputs: assert property ($fell(reset) |-> avs_waitrequest && !core_halted
    && avs_readdata == 32'h0)
    else $error("outputs wrong after reset");
  chk_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > OFS_DDATA
    |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_flag_bits: assert property (
    avs_read && avs_waitrequest && avs_address == OFS_FLAG |=> avs_readdata[31:4] == 28'h0)
    else $error("flag register wider than four bits");
  chk_halt_hold: assert property (core_halted && !avs_write |=> core_halted)
    else $error("halt released without a write");
endmodule : cbsd_core_chk

// >>> dv/cbsd_host_bfm.sv
`timescale 1ns/100ps
module cbsd_host_bfm
(
  input  wire logic        sys_clk,
  output logic      [5:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic             bus_hung
);
  initial
  begin
    avs_address = 6'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    bus_hung = 1'b0;
  end

  // Request held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50)
      bus_hung = 1'b1;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
endmodule : cbsd_host_bfm

// >>> dv/tb_cpu_branch_system_index_decode.sv
`timescale 1ns/100ps
module tb_cpu_branch_system_index_decode;
  import cbsd_pkg::*;
  logic        sys_clk;
  logic        reset;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        core_halted;
  logic        bus_hung;
  int          num_errors = 0;
  int          checks = 0;

  cbsd_core dut_u (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_halted(core_halted));
  cbsd_host_bfm host_u (.sys_clk(sys_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_hung(bus_hung));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_u.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    host_u.xfer(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic put(input logic [12:0] pa, input logic [11:0] w);
    wr(OFS_PADDR, {19'h0, pa});
    wr(OFS_PDATA, {20'h0, w});
  endtask : put

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    cmp(q, exp);
  endtask : rdchk

  task automatic memchk(input logic [11:0] da, input logic [3:0] exp);
    wr(OFS_DADDR, {20'h0, da});
    rdchk(OFS_DDATA, {28'h0, exp});
  endtask : memchk

  // Cycle count has a fixed offset; costs are taken as differences
  task automatic go(input logic [12:0] pc, output int c);
    wr(OFS_PC, {19'h0, pc});
    wr(OFS_CTRL, 32'h1);
    c = 0;
    do
    begin
      @(posedge sys_clk);
      c++;
    end
    while ((core_halted !== 1'b1 || c < 3) && c < 300);
    if (c >= 300)
    begin
      num_errors++;
      results();
    end
  endtask : go

  task automatic t_reset();
    rdchk(OFS_PC, 32'h100);
    rdchk(OFS_SP, 32'h0);
    rdchk(OFS_FLAG, 32'h0);
    rdchk(6'h3c, 32'h0);
  endtask : t_reset

  task automatic t_jump();
    int c;
    wr(OFS_AB, 32'h54);
    put(13'h0100, 12'he53);
    put(13'h0101, 12'h045);
    put(13'h0102, 12'hb11);
    put(13'h0103, 12'hff8);
    put(13'h1345, 12'hba7);
    put(13'h1346, 12'h83c);
    put(13'h1347, 12'hff8);
    go(13'h0100, c);
    rdchk(OFS_X, 32'ha7);
    rdchk(OFS_Y, 32'h3c);
    put(13'h0101, 12'hfe8);
    put(13'h1354, 12'hb5a);
    put(13'h1355, 12'hff8);
    go(13'h0100, c);
    rdchk(OFS_X, 32'h5a);
  endtask : t_jump

  task automatic t_cond();
    int c;
    logic f;
    logic [3:0] op;
    for (int i = 0; i < 8; i++)
    begin
      f = i[0];
      op = {1'b0, i[2], 1'b1, i[1]};
      wr(OFS_FLAG, {30'h0, f, f});
      put(13'h0100, 12'he41);
      put(13'h0101, {op, 8'h40});
      put(13'h0102, 12'hb22);
      put(13'h0103, 12'hff8);
      put(13'h0140, 12'hb33);
      put(13'h0141, 12'hff8);
      go(13'h0100, c);
      rdchk(OFS_X, ((i[1] ? !f : f) ? 32'h33 : 32'h22));
    end
  endtask : t_cond

  task automatic t_call();
    int c;
    for (int j = 0; j < 2; j++)
    begin
      wr(OFS_SP, 32'h40);
      wr(OFS_X, 32'h0);
      put(13'h0100, 12'he42);
      put(13'h0101, 12'h480);
      put(13'h0102, 12'hb55);
      put(13'h0103, 12'hff8);
      put(13'h0280, (j == 0) ? 12'hfdf : 12'hfde);
      go(13'h0100, c);
      rdchk(OFS_X, (j == 0) ? 32'h55 : 32'h0);
      rdchk(OFS_SP, 32'h40);
      memchk(12'h03f, 4'h1);
      memchk(12'h03e, 4'h0);
      memchk(12'h03d, 4'h2);
    end
  endtask : t_call

  task automatic t_return_with_data_op();
    int c;
    wr(OFS_SP, 32'h40);
    wr(OFS_X, 32'h20);
    put(13'h0100, 12'h590);
    put(13'h0101, 12'hff8);
    put(13'h0090, 12'h19c);
    go(13'h0100, c);
    rdchk(OFS_X, 32'h22);
    rdchk(OFS_SP, 32'h40);
    memchk(12'h020, 4'hc);
    memchk(12'h021, 4'h9);
    memchk(12'h03d, 4'h1);
  endtask : t_return_with_data_op

  // Decimal add through every register code: A, memory at X, memory at Y, B
  task automatic t_add();
    int c;
    wr(OFS_AB, 32'h70);
    wr(OFS_FLAG, 32'h4);
    wr(OFS_X, 32'h30);
    wr(OFS_Y, 32'h31);
    wr(OFS_DADDR, 32'h30);
    wr(OFS_DDATA, 32'h8);
    wr(OFS_DDATA, 32'h4);
    put(13'h0100, 12'hc01);
    put(13'h0101, 12'hc21);
    put(13'h0102, 12'hc36);
    put(13'h0103, 12'hc15);
    put(13'h0104, 12'hff8);
    go(13'h0100, c);
    rdchk(OFS_AB, 32'h21);
    rdchk(OFS_FLAG, 32'h5);
    memchk(12'h030, 4'h9);
    memchk(12'h031, 4'h0);
  endtask : t_add

  task automatic t_cost();
    int c0;
    int c;
    put(13'h0100, 12'hff8);
    go(13'h0100, c0);
    rdchk(OFS_CTRL, 32'h2);
    put(13'h0100, 12'hffb);
    put(13'h0101, 12'hff8);
    go(13'h0100, c);
    cmp(c - c0, 5);
    put(13'h0100, 12'hfff);
    go(13'h0100, c);
    cmp(c - c0, 7);
    wr(OFS_X, 32'hff);
    wr(OFS_FLAG, 32'h3);
    put(13'h0100, 12'hee0);
    go(13'h0100, c);
    cmp(c - c0, 5);
    rdchk(OFS_X, 32'h0);
    rdchk(OFS_FLAG, 32'h3);
  endtask : t_cost

  initial
  begin
    reset = 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_jump();
    t_cond();
    t_call();
    t_return_with_data_op();
    t_add();
    t_cost();
    results();
  end

  // Bounds the whole run and any stuck bus access
  initial
  begin : watchdog
    int n;
    n = 0;
    while (n < 90000 && bus_hung !== 1'b1)
    begin
      @(posedge sys_clk);
      n++;
    end
    num_errors++;
    results();
  end
endmodule : tb_cpu_branch_system_index_decode

bind cbsd_core cbsd_core_chk chk_u (.sys_clk(sys_clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .core_halted(core_halted));
